//--- hw/vga_seq_map.vh
// Purpose: Port addresses, indices, field positions and reset values
// Assumes: Included by vga_sequencer_memory_control.v
// Notes: Definitions only
`ifndef VGA_SEQ_MAP_VH
`define VGA_SEQ_MAP_VH
// ==================================================
// I/O ports
`define PORT_SEQ_INDEX 16'h03c4
`define PORT_SEQ_DATA 16'h03c5
`define PORT_MONO_TIM_INDEX 16'h03b4
`define PORT_MONO_TIM_DATA 16'h03b5
`define PORT_COLOR_TIM_INDEX 16'h03d4
`define PORT_COLOR_TIM_DATA 16'h03d5
// ==================================================
// Sequencer indices and the timing line total index
`define IDX_CLOCKING_MODE 6'h01
`define IDX_PLANE_WRITE_MASK 6'h02
`define IDX_FONT_BANK_SELECT 6'h03
`define IDX_MEMORY_ADDRESSING_MODE 6'h04
`define IDX_LINE_TOTAL_COUNT 6'h00
// ==================================================
// Timing extension indices
`define TIM_EXT_IDX_A 6'h19
`define TIM_EXT_IDX_B 6'h1a
`define TIM_EXT_IDX_C 6'h1b
`define TIM_EXT_IDX_D 6'h25
`define TIM_EXT_IDX_E 6'h27
// ==================================================
// Field positions
`define CLK_CHAR9_BIT 0
`define CLK_LOAD16_BIT 2
`define CLK_DOTDIV_BIT 3
`define CLK_LOAD32_BIT 4
`define MEM_EXTENDED_BIT 1
`define MEM_ODDEVEN_BIT 2
`define MEM_CHAIN4_BIT 3
// ==================================================
// Writable bit masks and reset values
`define CLK_WMASK 8'h3d
`define FONT_WMASK 8'h3f
`define MEM_WMASK 8'h0e
`define TIM_IDX_WMASK 8'h3f
`define RST_CLOCKING_MODE 8'h00
`define RST_PLANE_WRITE_MASK 8'h00
`define RST_FONT_BANK_SELECT 8'h00
`define RST_MEMORY_ADDRESSING_MODE 8'h00
`define RST_INDEX 8'h00
`define RST_LINE_TOTAL_COUNT 8'h00
// ==================================================
// Timing constants and graphics write mode codes
`define LINE_TOTAL_BIAS 9'h005
`define CHAR_DOTS_NARROW 4'h8
`define CHAR_DOTS_WIDE 4'h9
`define WRMODE_EXT4 3'h4
`define WRMODE_EXT5 3'h5
`define WRMODE_ONE 3'h1
`endif

//--- hw/vga_sequencer_memory_control.v
// Purpose: Sequencer clocking, write masking, font and memory addressing
// Assumes: Host I/O strobes synchronous to ref_clk
// Notes:
`timescale 1ns/1ps
`include "vga_seq_map.vh"
`default_nettype none
module vga_sequencer_memory_control (
    input wire ref_clk,
    input wire reset_n,
    input wire [15:0] ioAddr,
    input wire ioWrite,
    input wire ioRead,
    input wire [7:0] ioWrData,
    input wire colorMode,
    input wire [2:0] graphicsWriteMode,
    input wire graphicsExtensionEnable,
    input wire [1:0] cpuAddrLow,
    input wire [1:0] readPlaneSelect,
    input wire [7:0] charCode,
    input wire [7:0] attrByte,
    input wire [4:0] charRow,
    input wire [7:0] charCounter,
    input wire [7:0] cpuPixelWriteReq,
    input wire [7:0] blitPixelWriteReq,
    output reg [7:0] ioRdData,
    output reg ioRdValid,
    output reg dotClockEnable,
    output reg charClockPulse,
    output reg shifterLoadPulse,
    output reg [3:0] charDots,
    output reg [3:0] planeWriteEnable,
    output reg [7:0] pixelWriteEnable,
    output reg [7:0] blitWriteEnable,
    output reg [1:0] accessPlane,
    output reg [15:0] fontAddress,
    output reg [15:0] fontBankOffsetKb,
    output reg memoryLimit64k,
    output reg timingExtensionSelect,
    output reg lineTotalMatch,
    output reg [7:0] clocking_mode,
    output reg [7:0] memory_addressing_mode
);
// ==================================================
// Functions
function [2:0] bankOf;
    input [2:0] sel;
    begin
        bankOf = sel;
    end
endfunction
function [15:0] offsetKb;
    input [2:0] bank;
    begin
        offsetKb = {10'h000, bank[1:0], 4'h0}
            + {12'h000, bank[2], 3'h0};
    end
endfunction
function isTimExt;
    input [5:0] idx;
    begin
        isTimExt = (idx == `TIM_EXT_IDX_A) || (idx == `TIM_EXT_IDX_B)
            || (idx == `TIM_EXT_IDX_C) || (idx == `TIM_EXT_IDX_D)
            || (idx == `TIM_EXT_IDX_E);
    end
endfunction
function isExtWrite;
    input [2:0] mode;
    input extEnable;
    begin
        isExtWrite = (mode == `WRMODE_EXT4) || (mode == `WRMODE_EXT5)
            || (mode == `WRMODE_ONE && extEnable);
    end
endfunction
// ==================================================
// Registers
reg [7:0] plane_write_mask;
reg [7:0] font_bank_select;
reg [7:0] sequencer_index_pointer;
reg [7:0] timing_index_pointer;
reg [7:0] line_total_count;
reg dotPhase_ff;
reg [3:0] dotCount_ff;
reg [1:0] charCount_ff;
// ==================================================
// Port decode
wire seqIdxHit = (ioAddr == `PORT_SEQ_INDEX);
wire seqDatHit = (ioAddr == `PORT_SEQ_DATA);
wire timIdxHit = colorMode ? (ioAddr == `PORT_COLOR_TIM_INDEX)
    : (ioAddr == `PORT_MONO_TIM_INDEX);
wire timDatHit = colorMode ? (ioAddr == `PORT_COLOR_TIM_DATA)
    : (ioAddr == `PORT_MONO_TIM_DATA);
wire [5:0] seqIdx = sequencer_index_pointer[5:0];
wire [5:0] timIdx = timing_index_pointer[5:0];
wire timExt = isTimExt(timIdx);
wire lineTotHit = timDatHit && !timExt
    && (timIdx == `IDX_LINE_TOTAL_COUNT);
// ==================================================
// Register write
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        clocking_mode <= `RST_CLOCKING_MODE;
        plane_write_mask <= `RST_PLANE_WRITE_MASK;
        font_bank_select <= `RST_FONT_BANK_SELECT;
        memory_addressing_mode <= `RST_MEMORY_ADDRESSING_MODE;
        sequencer_index_pointer <= `RST_INDEX;
        timing_index_pointer <= `RST_INDEX;
        line_total_count <= `RST_LINE_TOTAL_COUNT;
    end else if (ioWrite) begin
        if (seqIdxHit) begin
            sequencer_index_pointer <= ioWrData;
        end
        if (timIdxHit) begin
            timing_index_pointer <= ioWrData & `TIM_IDX_WMASK;
        end
        if (lineTotHit) begin
            line_total_count <= ioWrData;
        end
        if (seqDatHit) begin
            case (seqIdx)
                `IDX_CLOCKING_MODE: clocking_mode <= ioWrData & `CLK_WMASK;
                `IDX_PLANE_WRITE_MASK: plane_write_mask <= ioWrData;
                `IDX_FONT_BANK_SELECT:
                    font_bank_select <= ioWrData & `FONT_WMASK;
                `IDX_MEMORY_ADDRESSING_MODE:
                    memory_addressing_mode <= ioWrData & `MEM_WMASK;
                default: ;
            endcase
        end
    end
end
// ==================================================
// Register read
reg [7:0] nxt_rd;
always @* begin
    nxt_rd = 8'h00;
    if (seqIdxHit)
        nxt_rd = sequencer_index_pointer;
    else if (timIdxHit)
        nxt_rd = timing_index_pointer;
    else if (lineTotHit)
        nxt_rd = line_total_count;
    else if (seqDatHit) begin
        case (seqIdx)
            `IDX_CLOCKING_MODE: nxt_rd = clocking_mode;
            `IDX_PLANE_WRITE_MASK: nxt_rd = plane_write_mask;
            `IDX_FONT_BANK_SELECT: nxt_rd = font_bank_select;
            `IDX_MEMORY_ADDRESSING_MODE: nxt_rd = memory_addressing_mode;
            default: nxt_rd = 8'h00;
        endcase
    end
end
// ==================================================
// Read data output
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        ioRdData <= 8'h00;
        ioRdValid <= 1'b0;
    end else begin
        ioRdData <= ioRead ? nxt_rd : 8'h00;
        ioRdValid <= ioRead;
    end
end
// ==================================================
// Dot, character and shifter clocks
wire dotDiv = clocking_mode[`CLK_DOTDIV_BIT];
wire nxtDot = dotDiv ? ~dotPhase_ff : 1'b1;
wire [3:0] nxtDots = clocking_mode[`CLK_CHAR9_BIT] ? `CHAR_DOTS_WIDE
    : `CHAR_DOTS_NARROW;
wire charEnd = nxtDot && (dotCount_ff >= nxtDots - 4'h1);
// ==================================================
// Shifter load select
reg nxt_load;
always @* begin
    if (clocking_mode[`CLK_LOAD32_BIT])
        nxt_load = charEnd && (charCount_ff == 2'h3);
    else if (clocking_mode[`CLK_LOAD16_BIT])
        nxt_load = charEnd && charCount_ff[0];
    else
        nxt_load = charEnd;
end
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        dotPhase_ff <= 1'b0;
        dotCount_ff <= 4'h0;
        charCount_ff <= 2'h0;
    end else begin
        dotPhase_ff <= dotDiv ? ~dotPhase_ff : 1'b0;
        if (charEnd) begin
            dotCount_ff <= 4'h0;
            charCount_ff <= charCount_ff + 2'h1;
        end else if (nxtDot)
            dotCount_ff <= dotCount_ff + 4'h1;
    end
end
// ==================================================
// Clock pulse outputs
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        dotClockEnable <= 1'b0;
        charClockPulse <= 1'b0;
        shifterLoadPulse <= 1'b0;
        charDots <= `CHAR_DOTS_NARROW;
    end else begin
        dotClockEnable <= nxtDot;
        charDots <= nxtDots;
        charClockPulse <= charEnd;
        shifterLoadPulse <= nxt_load;
    end
end
// ==================================================
// Write masking and memory addressing
wire extWrite = isExtWrite(graphicsWriteMode,
    graphicsExtensionEnable);
wire [7:0] extPixelMask = {{4{graphicsWriteMode[2]}}, 4'hf};
wire chain4 = memory_addressing_mode[`MEM_CHAIN4_BIT];
wire oddEven = ~memory_addressing_mode[`MEM_ODDEVEN_BIT];
wire extMem = memory_addressing_mode[`MEM_EXTENDED_BIT];
wire [2:0] priBank = bankOf({font_bank_select[4], font_bank_select[1:0]});
wire [2:0] secBank = bankOf({font_bank_select[5], font_bank_select[3:2]});
wire useSec = extMem && (priBank != secBank) && attrByte[3];
wire [2:0] fontBank = useSec ? secBank : priBank;
// ==================================================
// Plane select
reg [3:0] nxt_planes;
reg [1:0] nxt_plane;
always @* begin
    if (chain4) begin
        nxt_plane = cpuAddrLow;
        nxt_planes = 4'h1 << cpuAddrLow;
    end else if (oddEven) begin
        nxt_plane = {readPlaneSelect[1], cpuAddrLow[0]};
        nxt_planes = cpuAddrLow[0] ? 4'ha : 4'h5;
    end else begin
        nxt_plane = readPlaneSelect;
        nxt_planes = 4'hf;
    end
end
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        planeWriteEnable <= 4'h0;
        pixelWriteEnable <= 8'h00;
        blitWriteEnable <= 8'h00;
        accessPlane <= 2'h0;
    end else begin
        planeWriteEnable <= extWrite ? 4'hf
            : (plane_write_mask[3:0] & nxt_planes);
        pixelWriteEnable <= extWrite
            ? (plane_write_mask & extPixelMask & cpuPixelWriteReq)
            : {4'h0, cpuPixelWriteReq[3:0]};
        blitWriteEnable <= plane_write_mask & blitPixelWriteReq;
        accessPlane <= nxt_plane;
    end
end
// ==================================================
// Font address outputs
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        fontAddress <= 16'h0000;
        fontBankOffsetKb <= 16'h0000;
    end else begin
        fontAddress <= {fontBank, charCode, charRow};
        fontBankOffsetKb <= offsetKb(fontBank);
    end
end
// ==================================================
// Status outputs
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        memoryLimit64k <= 1'b1;
        timingExtensionSelect <= 1'b0;
        lineTotalMatch <= 1'b0;
    end else begin
        memoryLimit64k <= ~extMem;
        timingExtensionSelect <= timExt;
        lineTotalMatch <= ({1'b0, charCounter} ==
            {1'b0, line_total_count} + `LINE_TOTAL_BIAS);
    end
end
endmodule // vga_sequencer_memory_control
`default_nettype wire

//--- tb/vga_seq_chk.sv
// Purpose: Port-level assertions for the sequencer block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the design top module
`timescale 1ns/1ps
`default_nettype none
module vga_seq_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ioRead,
    input wire logic [2:0] graphicsWriteMode,
    input wire logic [1:0] cpuAddrLow,
    input wire logic [7:0] cpuPixelWriteReq,
    input wire logic [7:0] blitPixelWriteReq,
    input wire logic ioRdValid,
    input wire logic dotClockEnable,
    input wire logic [3:0] charDots,
    input wire logic [7:0] pixelWriteEnable,
    input wire logic [7:0] blitWriteEnable,
    input wire logic [1:0] accessPlane,
    input wire logic memoryLimit64k,
    input wire logic [7:0] clocking_mode,
    input wire logic [7:0] memory_addressing_mode
);
    // ==========
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_halfOn;
        clocking_mode[3] [*3];
    endsequence
    AST_DOT_HALF: assert property (s_halfOn |->
        dotClockEnable != $past(dotClockEnable)) else $error("no halving");
    AST_DOT_FULL: assert property ($past(reset_n) &&
        !clocking_mode[3] ##1 !clocking_mode[3] |-> dotClockEnable)
        else $error("dot clock not full rate");
    AST_CHAR_DOTS: assert property ($past(reset_n) &&
        $stable(clocking_mode[0]) |-> charDots == (clocking_mode[0] ? 4'h9 :
        4'h8)) else $error("character width wrong");
    AST_PIX_MASK: assert property (
        (pixelWriteEnable & ~$past(cpuPixelWriteReq)) == 8'h00)
        else $error("pixel written without request");
    AST_BLIT_MASK: assert property (
        (blitWriteEnable & ~$past(blitPixelWriteReq)) == 8'h00)
        else $error("blit written without request");
    AST_UPPER_RSV: assert property (!$past(graphicsWriteMode[2]) |->
        pixelWriteEnable[7:4] == 4'h0) else $error("upper mask active");
    AST_CHAIN4: assert property ($past(reset_n) &&
        $stable(memory_addressing_mode) && memory_addressing_mode[3] |->
        accessPlane == $past(cpuAddrLow)) else $error("chain-4 plane wrong");
    AST_ODD_EVEN: assert property ($past(reset_n) &&
        $stable(memory_addressing_mode) && memory_addressing_mode[3:2] == 2'h0
        |-> accessPlane[0] == $past(cpuAddrLow[0])) else $error("odd/even");
    AST_MEM64: assert property ($past(reset_n) &&
        $stable(memory_addressing_mode) |->
        memoryLimit64k == !memory_addressing_mode[1]) else $error("64K limit");
    AST_RD_ANSWER: assert property (ioRdValid |-> $past(ioRead))
        else $error("read answer without read");
endmodule // vga_seq_chk
bind vga_sequencer_memory_control vga_seq_chk u_chk (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ioRead(ioRead),
    .graphicsWriteMode(graphicsWriteMode),
    .cpuAddrLow(cpuAddrLow),
    .cpuPixelWriteReq(cpuPixelWriteReq),
    .blitPixelWriteReq(blitPixelWriteReq),
    .ioRdValid(ioRdValid),
    .dotClockEnable(dotClockEnable),
    .charDots(charDots),
    .pixelWriteEnable(pixelWriteEnable),
    .blitWriteEnable(blitWriteEnable),
    .accessPlane(accessPlane),
    .memoryLimit64k(memoryLimit64k),
    .clocking_mode(clocking_mode),
    .memory_addressing_mode(memory_addressing_mode)
);
`default_nettype wire

//--- tb/host_io_model.sv
// Purpose: Host processor issuing indexed I/O cycles
// Assumes: Strobes change 1 ns after the rising edge
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
    input wire logic ref_clk,
    input wire logic [7:0] ioRdData,
    output var logic [15:0] ioAddr = 16'h0000,
    output var logic ioWrite = 1'b0,
    output var logic ioRead = 1'b0,
    output var logic [7:0] ioWrData = 8'h00
);
    // ==========
    // One I/O cycle, write when w is 1
    task acc(input w, input [15:0] a, input [7:0] v, output [7:0] q);
        @(posedge ref_clk);
        #1;
        {ioAddr, ioWrData, ioWrite, ioRead} = {a, v, w, !w};
        @(posedge ref_clk);
        #1;
        {ioAddr, ioWrData, ioWrite, ioRead} = {~a, ~v, 2'b00};
        q = ioRdData;
    endtask
endmodule // host_io_model
`default_nettype wire

//--- tb/vga_sequencer_memory_control_tb.sv
// Purpose: Directed test of the sequencer register block
// Assumes: Host model drives the I/O strobes
// Notes: Expected values follow the register map
`timescale 1ns/1ps
`default_nettype none
module vga_sequencer_memory_control_tb;
    logic ref_clk = 1'b0, reset_n = 1'b0, colorMode = 1'b0;
    logic graphicsExtensionEnable = 1'b0;
    logic [2:0] graphicsWriteMode = 3'h0, fa;
    logic [1:0] cpuAddrLow = 2'h0, readPlaneSelect = 2'h1, accessPlane;
    logic [7:0] charCode = 8'h5a, attrByte = 8'h00, charCounter = 8'h00;
    logic [4:0] charRow = 5'h13;
    logic [7:0] cpuPixelWriteReq = 8'hff, blitPixelWriteReq = 8'h3c;
    logic [15:0] ioAddr, fontAddress, fontBankOffsetKb;
    logic ioWrite, ioRead, ioRdValid, dotClockEnable, charClockPulse;
    logic shifterLoadPulse, memoryLimit64k, timingExtensionSelect;
    logic lineTotalMatch;
    logic [7:0] ioWrData, ioRdData, pixelWriteEnable, blitWriteEnable, d;
    logic [7:0] clocking_mode, memory_addressing_mode;
    logic [3:0] charDots, planeWriteEnable;
    logic [7:0] xi [5] = '{8'h19, 8'h1a, 8'h1b, 8'h25, 8'h27};
    int fail_count = 0, checks = 0;
    vga_sequencer_memory_control uut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ioAddr(ioAddr),
        .ioWrite(ioWrite),
        .ioRead(ioRead),
        .ioWrData(ioWrData),
        .colorMode(colorMode),
        .graphicsWriteMode(graphicsWriteMode),
        .graphicsExtensionEnable(graphicsExtensionEnable),
        .cpuAddrLow(cpuAddrLow),
        .readPlaneSelect(readPlaneSelect),
        .charCode(charCode),
        .attrByte(attrByte),
        .charRow(charRow),
        .charCounter(charCounter),
        .cpuPixelWriteReq(cpuPixelWriteReq),
        .blitPixelWriteReq(blitPixelWriteReq),
        .ioRdData(ioRdData),
        .ioRdValid(ioRdValid),
        .dotClockEnable(dotClockEnable),
        .charClockPulse(charClockPulse),
        .shifterLoadPulse(shifterLoadPulse),
        .charDots(charDots),
        .planeWriteEnable(planeWriteEnable),
        .pixelWriteEnable(pixelWriteEnable),
        .blitWriteEnable(blitWriteEnable),
        .accessPlane(accessPlane),
        .fontAddress(fontAddress),
        .fontBankOffsetKb(fontBankOffsetKb),
        .memoryLimit64k(memoryLimit64k),
        .timingExtensionSelect(timingExtensionSelect),
        .lineTotalMatch(lineTotalMatch),
        .clocking_mode(clocking_mode),
        .memory_addressing_mode(memory_addressing_mode)
    );
    host_io_model h (
        .ref_clk(ref_clk),
        .ioRdData(ioRdData),
        .ioAddr(ioAddr),
        .ioWrite(ioWrite),
        .ioRead(ioRead),
        .ioWrData(ioWrData)
    );
    always #20 ref_clk = ~ref_clk;
    // ==========
    // Helpers
    task chk(input [23:0] got, input [23:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task rs(input [15:0] p, input [7:0] i, input [7:0] v);
        h.acc(1'b1, p, i, d);
        h.acc(1'b1, p + 16'h0001, v, d);
        settle;
    endtask
    task rate(input [7:0] m, input int dv, input int ch);
        int nc, nl;
        nc = 0;
        nl = 0;
        rs(16'h03c4, 8'h01, m);
        repeat (360) begin
            @(posedge ref_clk);
            #1;
            nc += charClockPulse;
            nl += shifterLoadPulse;
        end
        chk(nc >= ch - 1 && nc <= ch + 1, 1'b1);
        chk(nl * dv <= nc + dv && nc <= nl * dv + dv, 1'b1);
    endtask
    task end_sim;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        end_sim;
    end
    // ==========
    // Tests
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        settle;
        chk({charDots, 3'h0, memoryLimit64k}, 8'h81);
        chk({clocking_mode, memory_addressing_mode}, 16'h0000);
        rs(16'h03c4, 8'h02, 8'ha5);
        h.acc(1'b0, 16'h03c5, 8'h00, d);
        chk(d, 8'ha5);
        chk(planeWriteEnable, 4'h5);
        graphicsWriteMode = 3'h4;
        settle;
        chk({pixelWriteEnable, blitWriteEnable}, 16'ha524);
        cpuPixelWriteReq = 8'h3c;
        settle;
        chk(pixelWriteEnable, 8'h24);
        cpuPixelWriteReq = 8'hff;
        graphicsWriteMode = 3'h1;
        graphicsExtensionEnable = 1'b1;
        settle;
        chk(pixelWriteEnable, 8'h05);
        rs(16'h03c4, 8'h01, 8'hff);
        h.acc(1'b0, 16'h03c5, 8'h00, d);
        chk(d, 8'h3d);
        rate(8'h00, 1, 45);
        rate(8'h04, 2, 45);
        rate(8'h10, 4, 45);
        rate(8'h09, 1, 20);
        rs(16'h03c4, 8'h03, 8'h3f);
        chk(fontBankOffsetKb, 16'h0038);
        chk(fontAddress, {3'h7, charCode, charRow});
        rs(16'h03c4, 8'h03, 8'h12);
        chk({fontBankOffsetKb, 5'h0, fontAddress[15:13]}, 24'h2806);
        for (int m = 0; m < 2; m++) begin
            rs(16'h03c4, 8'h04, m ? 8'h0a : 8'h02);
            for (int i = 0; i < 4; i++) begin
                cpuAddrLow = i[1:0];
                settle;
                chk(accessPlane & (m ? 2'h3 : 2'h1), i & (m ? 3 : 1));
            end
        end
        chk(memoryLimit64k, 1'b0);
        fa = fontAddress[15:13];
        attrByte = 8'h08;
        settle;
        chk(fa ^ fontAddress[15:13], 3'h6);
        rs(16'h03c4, 8'h04, 8'h00);
        colorMode = 1'b1;
        rs(16'h03d4, 8'h00, 8'h4b);
        h.acc(1'b1, 16'h03b5, 8'h11, d);
        h.acc(1'b0, 16'h03d5, 8'h00, d);
        chk(d, 8'h4b);
        charCounter = 8'h50;
        settle;
        chk(lineTotalMatch, 1'b1);
        charCounter = 8'h4f;
        settle;
        chk(lineTotalMatch, 1'b0);
        for (int i = 0; i < 5; i++) begin
            h.acc(1'b1, 16'h03d4, xi[i], d);
            settle;
            chk(timingExtensionSelect, 1'b1);
        end
        h.acc(1'b1, 16'h03d4, 8'hff, d);
        settle;
        chk(timingExtensionSelect, 1'b0);
        colorMode = 1'b0;
        h.acc(1'b0, 16'h03b4, 8'h00, d);
        chk(d, 8'h3f);
        h.acc(1'b0, 16'h0300, 8'h00, d);
        chk(d, 8'h00);
        end_sim;
    end
endmodule // vga_sequencer_memory_control_tb
`default_nettype wire
